// file: design/dmade_channel_priority_level_pick.sv
/*
 * Priority decoder: picks the highest priority activated channel.
 * Purely combinational, evaluated for all channels every cycle.
 */
module dmade_channel_priority_level_pick
    import dmade_pkg::*;
#(
    parameter int NCH = 8
)
(
    // requests
    input  wire logic [NCH-1:0]                   i_req,
    input  wire logic [NCH-1:0][DMADE_CHANNEL_PRIORITY_LEVEL_W-1:0] i_channel_priority_level,
    // choice
    output logic                                  o_valid,
    output logic [$clog2(NCH)-1:0]                o_idx
);

    logic [2:0] best_p;

    always_comb
    begin
        best_p  = DMADE_CHANNEL_PRIORITY_LEVEL_NONE;
        o_idx   = '0;
        for (int c = 0; c < NCH; c++)
        begin
            if (i_req[c] && ({1'b0, i_channel_priority_level[c]} < best_p))
            begin
                best_p = {1'b0, i_channel_priority_level[c]};
                o_idx  = c[$clog2(NCH)-1:0];
            end
        end
        o_valid = (best_p != DMADE_CHANNEL_PRIORITY_LEVEL_NONE);
    end

endmodule

// file: design/dmade_engine.sv
/*
 * Descriptor transfer engine: pending triggers, priority pick, two
 * descriptors per channel, shared sequential engine driving an AHB-Lite
 * master, descriptor write-back and completion pulse.
 * Assumes software writes descriptors through the config port and that
 * the bus arbiter answers with HREADY; HRESP errors are not handled.
 */
// Summary of operation
// - element width is 8, 16 or 32
// - access widths are element width or 32
// - narrow element drops upper read bits
// - narrow element zero pads a 32-bit write, replicates across lanes on a narrow write
// - select bit picks active descriptor per channel
// - chain mode with swap runs next descriptor
// - swap in modes 0/1 waits new trigger
// - mode 0 moves one element per trigger
// - mode 0 steps destination until count reached
// - mode 1 moves whole descriptor per trigger
// - chained descriptors alternate until invalidated
// - trigger and priority evaluated per channel
// - load active descriptor before bus access
// - each element is read then write
// - write updated descriptor state back
// - completion interrupt only when enabled
// - single element takes 12 cycles plus waits
// - later elements take 3 cycles plus waits
// - priority 0 highest, lowest channel wins ties
// - address step equals access width size
// - invalidate on done clears valid flag
module dmade_engine
    import dmade_pkg::*;
#(
    parameter int NCH = 8
)
(
    // clock and reset
    input  wire logic                               i_clk_sys,
    input  wire logic                               i_rst_n,
    // triggers and channel control
    input  wire logic [NCH-1:0]                     i_trig,
    input  wire logic [NCH-1:0]                     i_ch_en,
    input  wire logic [NCH-1:0][DMADE_CHANNEL_PRIORITY_LEVEL_W-1:0]   i_ch_channel_priority_level,
    input  wire logic                               i_sel_wr,
    input  wire logic [$clog2(NCH)-1:0]             i_sel_ch,
    input  wire logic                               i_sel_val,
    // descriptor programming
    input  wire logic                               i_cfg_wr,
    input  wire logic [$clog2(NCH)-1:0]             i_cfg_ch,
    input  wire logic                               i_cfg_idx,
    input  wire dmade_desc_s                        i_cfg_desc,
    // bus master
    output dmade_ahb_req_s                          o_ahb,
    input  wire logic [31:0]                        i_hrdata,
    input  wire logic                               i_hready,
    // status
    output logic [NCH-1:0]                          o_desc_select,
    output logic [NCH-1:0]                          o_pending,
    output logic                                    o_busy,
    output logic [$clog2(NCH)-1:0]                  o_active_ch,
    output logic                                    o_irq,
    output logic [$clog2(NCH)-1:0]                  o_irq_ch
);

    localparam int CW = $clog2(NCH);

    // ==========================================================
    // width helpers
    function automatic logic [1:0] step_shift(input logic aw, input logic [1:0] ew);
        step_shift = (aw == DMADE_AW_32) ? DMADE_EW_32 : ew;
    endfunction

    function automatic logic [31:0] addr_of(input logic [31:0] base, input logic step,
                                            input logic [1:0] sh, input logic [15:0] idx);
        logic [31:0] off;
        off     = step ? ({16'h0000, idx} << sh) : 32'h0000_0000;
        addr_of = base + off;
    endfunction

    function automatic logic [31:0] elem_mask(input logic [31:0] v, input logic [1:0] ew);
        unique case (ew)
            DMADE_EW_8:  elem_mask = {24'h00_0000, v[7:0]};
            DMADE_EW_16: elem_mask = {16'h0000, v[15:0]};
            default:     elem_mask = v;
        endcase
    endfunction

    // ==========================================================
    // state
    dmade_state_e            state_ff;
    logic [1:0]              cnt_ff;
    logic [CW-1:0]           ch_ff;
    dmade_desc_s             cur_ff;
    logic [31:0]             data_ff;
    logic                    done_ff;
    logic [NCH-1:0]          pend_ff;
    logic [NCH-1:0]          sel_ff;
    logic                    irq_ff;
    logic [CW-1:0]           irq_ch_ff;
    dmade_desc_s             desc_mem [2*NCH];

    logic                    pick_valid;
    logic [CW-1:0]           pick_idx;
    logic [NCH-1:0]          accept;
    logic [31:0]             src_a;
    logic [31:0]             dst_a;
    logic [15:0]             nxt_index;
    logic                    last_elem;
    logic                    chain_go;
    logic                    wd_done;

    dmade_channel_priority_level_pick #(
        .NCH     (NCH)
    ) u_pick (
        .i_req   (pend_ff & i_ch_en),
        .i_channel_priority_level  (i_ch_channel_priority_level),
        .o_valid (pick_valid),
        .o_idx   (pick_idx)
    );

    assign src_a     = addr_of(cur_ff.src_addr, cur_ff.source_step_enable,
                               step_shift(cur_ff.source_access_width, cur_ff.elem_width), cur_ff.cur_index);
    assign dst_a     = addr_of(cur_ff.dst_addr, cur_ff.dest_step_enable,
                               step_shift(cur_ff.dest_access_width, cur_ff.elem_width), cur_ff.cur_index);
    assign nxt_index = cur_ff.cur_index + 16'h0001;
    assign last_elem = (nxt_index >= cur_ff.element_count);
    assign wd_done   = (state_ff == DMADE_ST_WD) && i_hready;
    assign chain_go  = done_ff && cur_ff.auto_swap && (cur_ff.mode == DMADE_MODE_CHAIN);

    always_comb
    begin
        accept = '0;
        if ((state_ff == DMADE_ST_IDLE) && pick_valid)
        begin
            accept[pick_idx] = 1'b1;
        end
    end

    // ==========================================================
    // pending triggers
    // a trigger in the accept cycle re-arms the channel
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pend_ff <= '0;
        end
        else
        begin
            pend_ff <= (pend_ff & ~accept) | (i_trig & i_ch_en);
        end
    end

    // ==========================================================
    // engine sequencer
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_ff <= DMADE_ST_IDLE;
            cnt_ff   <= 2'h0;
            ch_ff    <= '0;
        end
        else
        begin
            unique case (state_ff)
                DMADE_ST_IDLE:
                begin
                    cnt_ff <= 2'h0;
                    if (pick_valid)
                    begin
                        ch_ff    <= pick_idx;
                        state_ff <= DMADE_ST_LOAD;
                    end
                end
                DMADE_ST_LOAD:
                begin
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == DMADE_LOAD_LAST)
                    begin
                        cnt_ff   <= 2'h0;
                        state_ff <= cur_ff.valid ? DMADE_ST_RA : DMADE_ST_RESP;
                    end
                end
                DMADE_ST_RA:
                begin
                    if (i_hready)
                    begin
                        state_ff <= DMADE_ST_RD_WA;
                    end
                end
                DMADE_ST_RD_WA:
                begin
                    if (i_hready)
                    begin
                        state_ff <= DMADE_ST_WD;
                    end
                end
                DMADE_ST_WD:
                begin
                    // next element restarts at read address
                    if (i_hready)
                    begin
                        state_ff <= (!last_elem && (cur_ff.mode != DMADE_MODE_ONE)) ?
                                    DMADE_ST_RA : DMADE_ST_STORE;
                    end
                end
                DMADE_ST_STORE:
                begin
                    cnt_ff <= cnt_ff + 2'h1;
                    if (cnt_ff == DMADE_STORE_LAST)
                    begin
                        cnt_ff   <= 2'h0;
                        state_ff <= DMADE_ST_RESP;
                    end
                end
                DMADE_ST_RESP:
                begin
                    // no swap ends the trigger here
                    state_ff <= chain_go ? DMADE_ST_LOAD : DMADE_ST_IDLE;
                end
                default:
                begin
                    state_ff <= DMADE_ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // working descriptor and data
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cur_ff  <= '0;
            data_ff <= 32'h0000_0000;
            done_ff <= 1'b0;
        end
        else
        begin
            if ((state_ff == DMADE_ST_LOAD) && (cnt_ff == 2'h0))
            begin
                cur_ff  <= desc_mem[{ch_ff, sel_ff[ch_ff]}];
                done_ff <= 1'b0;
            end
            if ((state_ff == DMADE_ST_RD_WA) && i_hready)
            begin
                data_ff <= elem_mask((cur_ff.source_access_width == DMADE_AW_32) ?
                                     i_hrdata : (i_hrdata >> {src_a[1:0], 3'b000}),
                                     cur_ff.elem_width);
            end
            if (wd_done)
            begin
                if (last_elem)
                begin
                    done_ff          <= 1'b1;
                    cur_ff.cur_index <= 16'h0000;
                    if (cur_ff.invalidate_on_done)
                    begin
                        cur_ff.valid <= 1'b0;
                    end
                end
                else
                begin
                    cur_ff.cur_index <= nxt_index;
                end
            end
        end
    end

    // ==========================================================
    // descriptor storage; software write wins a same-slot collision
    always_ff @(posedge i_clk_sys)
    begin
        if ((state_ff == DMADE_ST_STORE) && (cnt_ff == 2'h0))
        begin
            desc_mem[{ch_ff, sel_ff[ch_ff]}] <= cur_ff;
        end
        if (i_cfg_wr)
        begin
            desc_mem[{i_cfg_ch, i_cfg_idx}] <= i_cfg_desc;
        end
    end

    // ==========================================================
    // descriptor select; the hardware swap wins over a software write
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sel_ff <= '0;
        end
        else
        begin
            if (i_sel_wr)
            begin
                sel_ff[i_sel_ch] <= i_sel_val;
            end
            // swap on completion in every mode
            if ((state_ff == DMADE_ST_RESP) && done_ff && cur_ff.auto_swap)
            begin
                sel_ff[ch_ff] <= ~sel_ff[ch_ff];
            end
        end
    end

    // ==========================================================
    // completion pulse
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_ff    <= 1'b0;
            irq_ch_ff <= '0;
        end
        else
        begin
            irq_ff    <= (state_ff == DMADE_ST_RESP) && done_ff && cur_ff.irq_en;
            irq_ch_ff <= ch_ff;
        end
    end

    // ==========================================================
    // bus master drive
    always_comb
    begin
        o_ahb        = '0;
        o_ahb.htrans = DMADE_HTRANS_IDLE;
        if (state_ff == DMADE_ST_RA)
        begin
            o_ahb.htrans = DMADE_HTRANS_NONSEQ;
            o_ahb.haddr  = src_a;
            o_ahb.hsize  = (cur_ff.source_access_width == DMADE_AW_32) ?
                           DMADE_HSIZE_WORD : {1'b0, cur_ff.elem_width};
        end
        else if (state_ff == DMADE_ST_RD_WA)
        begin
            o_ahb.htrans = DMADE_HTRANS_NONSEQ;
            o_ahb.hwrite = 1'b1;
            o_ahb.haddr  = dst_a;
            o_ahb.hsize  = (cur_ff.dest_access_width == DMADE_AW_32) ?
                           DMADE_HSIZE_WORD : {1'b0, cur_ff.elem_width};
        end
        else if (state_ff == DMADE_ST_WD)
        begin
            if (cur_ff.dest_access_width == DMADE_AW_32)
            begin
                o_ahb.hwdata = data_ff;
            end
            else
            begin
                // narrow write: replicate across lanes so any address works
                unique case (cur_ff.elem_width)
                    DMADE_EW_8:  o_ahb.hwdata = {4{data_ff[7:0]}};
                    DMADE_EW_16: o_ahb.hwdata = {2{data_ff[15:0]}};
                    default:     o_ahb.hwdata = data_ff;
                endcase
            end
        end
    end

    assign o_desc_select = sel_ff;
    assign o_pending     = pend_ff;
    assign o_busy        = (state_ff != DMADE_ST_IDLE);
    assign o_active_ch   = ch_ff;
    assign o_irq         = irq_ff;
    assign o_irq_ch      = irq_ch_ff;

endmodule

// file: design/dmade_pkg.sv
/*
 * Shared types and constants of the descriptor transfer engine:
 * descriptor layout, width and mode codes, engine states, cycle budgets.
 * Assumes a single system clock and an AHB-Lite style master port.
 */
package dmade_pkg;

    // ==========================================================
    // element width and mode codes
    localparam logic [1:0] DMADE_EW_8    = 2'h0;
    localparam logic [1:0] DMADE_EW_16   = 2'h1;
    localparam logic [1:0] DMADE_EW_32   = 2'h2;
    localparam logic       DMADE_AW_ELEM = 1'h0;
    localparam logic       DMADE_AW_32   = 1'h1;
    localparam logic [1:0] DMADE_MODE_ONE   = 2'h0;
    localparam logic [1:0] DMADE_MODE_DESC  = 2'h1;
    localparam logic [1:0] DMADE_MODE_CHAIN = 2'h2;

    // ==========================================================
    // bus codes
    localparam logic [1:0] DMADE_HTRANS_IDLE   = 2'h0;
    localparam logic [1:0] DMADE_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] DMADE_HSIZE_WORD    = 3'h2;

    // ==========================================================
    // cycle budget: accept 1 + load 3 + element 3 + store 4 + response 1 = 12
    localparam int         DMADE_FIRST_ELEM_CYC = 12;
    localparam int         DMADE_NEXT_ELEM_CYC  = 3;
    localparam logic [1:0] DMADE_LOAD_LAST      = 2'h2;
    localparam logic [1:0] DMADE_STORE_LAST     = 2'h3;
    localparam int         DMADE_CHANNEL_PRIORITY_LEVEL_W         = 2;
    localparam logic [2:0] DMADE_CHANNEL_PRIORITY_LEVEL_NONE      = 3'h4;

    // ==========================================================
    // descriptor word as held in descriptor storage
    typedef struct packed {
        logic        valid;
        logic        irq_en;
        logic        invalidate_on_done;
        logic        auto_swap;
        logic [1:0]  mode;
        logic        source_step_enable;
        logic        dest_step_enable;
        logic        source_access_width;
        logic        dest_access_width;
        logic [1:0]  elem_width;
        logic [15:0] element_count;
        logic [15:0] cur_index;
        logic [31:0] src_addr;
        logic [31:0] dst_addr;
    } dmade_desc_s;

    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
    } dmade_ahb_req_s;

    typedef enum logic [2:0] {
        DMADE_ST_IDLE  = 3'b000,
        DMADE_ST_LOAD  = 3'b001,
        DMADE_ST_RA    = 3'b010,
        DMADE_ST_RD_WA = 3'b011,
        DMADE_ST_WD    = 3'b100,
        DMADE_ST_STORE = 3'b101,
        DMADE_ST_RESP  = 3'b110
    } dmade_state_e;

endpackage

// file: test/dmade_ahb_mem.sv
/*
 * Bus memory model: 64 words, byte lanes, fixed wait states.
 * Assumes the bench preloads and inspects the array.
 */
module dmade_ahb_mem
    import dmade_pkg::*;
(
    // clock and reset
    input  wire logic           i_clk_sys,
    input  wire logic           i_rst_n,
    // bus
    input  wire dmade_ahb_req_s i_ahb,
    input  wire logic [1:0]     i_waits,
    output logic [31:0]         o_hrdata,
    output logic                o_hready
);
    logic [31:0] mem [64];
    logic        dp, wr;
    logic [2:0]  sz;
    logic [7:0]  ad;
    logic [1:0]  cnt;

    // ====================
    // data phase
    assign o_hready = !dp || cnt == 2'h0;
    // outside a finished read the lines show the inverse, not stale data
    assign o_hrdata = (dp && !wr && o_hready) ? mem[ad[7:2]] : ~mem[ad[7:2]];
    always @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dp <= 1'b0;
            ad <= 8'h0;
            cnt <= 2'h0;
        end
        else if (o_hready)
        begin
            for (int b = 0; b < 4; b++)
                if (dp && wr && (sz == 3'h2 || (sz == 3'h1 && b / 2 == ad[1]) || b == ad[1:0]))
                    mem[ad[7:2]][b*8 +: 8] <= i_ahb.hwdata[b*8 +: 8];
            dp <= i_ahb.htrans == DMADE_HTRANS_NONSEQ;
            wr <= i_ahb.hwrite;
            sz <= i_ahb.hsize;
            ad <= i_ahb.haddr[7:0];
            cnt <= i_waits;
        end
        else
            cnt <= cnt - 2'h1;
    end
endmodule

// file: test/dmade_engine_sva.sv
/*
 * Port checker: trigger capture, load, bus order, stalls, timing.
 * Assumes a bind from the bench top and one clock.
 */
module dmade_engine_sva
    import dmade_pkg::*;
#(
    parameter int NCH = 8
)
(
    // clock and reset
    input wire logic                   i_clk_sys,
    input wire logic                   i_rst_n,
    // watched ports
    input wire logic [NCH-1:0]         i_trig,
    input wire logic [NCH-1:0]         i_ch_en,
    input wire logic                   i_hready,
    input wire dmade_ahb_req_s         o_ahb,
    input wire logic [NCH-1:0]         o_pending,
    input wire logic                   o_busy,
    input wire logic                   o_irq
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // ====================
    // helper decode
    logic           rd, wr, idle_bus, wd_ff, wd_done;
    logic [NCH-1:0] trig_en;
    assign rd       = o_ahb.htrans == DMADE_HTRANS_NONSEQ && !o_ahb.hwrite;
    assign wr       = o_ahb.htrans == DMADE_HTRANS_NONSEQ && o_ahb.hwrite;
    assign idle_bus = o_ahb.htrans == DMADE_HTRANS_IDLE;
    assign wd_done  = wd_ff && i_hready;
    assign trig_en  = i_trig & i_ch_en;
    // write data phase lasts until the slave is ready
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wd_ff <= 1'b0;
        else
            wd_ff <= (wr && i_hready) || (wd_ff && !i_hready);
    end

    // ====================
    // assertions
    a_pend_on_trig: assert property (|trig_en |=> (o_pending & $past(trig_en)) == $past(trig_en))
        else $error("pending not set by trigger");
    a_accept_busy: assert property (!o_busy && |(o_pending & i_ch_en) |=> o_busy)
        else $error("pending channel not accepted");
    a_load_first: assert property ($rose(o_busy) |-> idle_bus [*3])
        else $error("bus access during descriptor load");
    a_read_then_write: assert property (rd && i_hready |=> wr)
        else $error("read not followed by write");
    a_write_then_data: assert property (wr && i_hready |=> idle_bus && o_busy)
        else $error("write address not followed by data");
    a_hold_address: assert property (!idle_bus && !i_hready |=> $stable(o_ahb.haddr) && $stable(o_ahb.htrans))
        else $error("address moved during wait");
    a_hold_data: assert property (wd_ff && !i_hready |=> $stable(o_ahb.hwdata) && idle_bus)
        else $error("write data moved during wait");
    a_next_element: assert property (wd_done |=> rd or ((o_busy && idle_bus) [*5]))
        else $error("wrong gap after element");
    a_done_pulse: assert property (o_irq |-> $past(wd_done, 6))
        else $error("completion pulse off time");

    c_irq: cover property (o_irq);
    c_stall: cover property (wd_ff && !i_hready);
    c_burst: cover property (wd_done ##1 rd);
endmodule

// file: test/tb_dmade_engine.sv
/*
 * Engine bench: width table, modes 0 to 2, priority order.
 * Assumes the checker and memory model are compiled with it.
 */
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_dmade_engine
    import dmade_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NCH = 4;
    // ====================
    // signals
    logic                i_clk_sys = 1'b0;
    logic                i_rst_n, i_sel_wr, i_sel_val, i_cfg_wr, i_cfg_idx, i_hready, o_busy, o_irq;
    logic [NCH-1:0]      i_trig, i_ch_en, o_desc_select, o_pending, trig_m;
    logic [NCH-1:0][1:0] i_ch_channel_priority_level;
    logic [1:0]          i_sel_ch, i_cfg_ch, o_active_ch, o_irq_ch, ew, aw, order[$];
    dmade_desc_s         i_cfg_desc;
    dmade_ahb_req_s      o_ahb;
    logic [31:0]         i_hrdata, e, g;
    logic [1:0]          waits = 2'h0;
    logic                busy_q = 1'b0;
    int                  nb, a;
    int                  failures = 0, check_count = 0, irq_cnt = 0;

    dmade_engine #(.NCH(NCH)) u_dmade_engine (.i_clk_sys, .i_rst_n, .i_trig, .i_ch_en, .i_ch_channel_priority_level, .i_sel_wr,
        .i_sel_ch, .i_sel_val, .i_cfg_wr, .i_cfg_ch, .i_cfg_idx, .i_cfg_desc, .o_ahb, .i_hrdata, .i_hready,
        .o_desc_select, .o_pending, .o_busy, .o_active_ch, .o_irq, .o_irq_ch);
    dmade_ahb_mem u_dmade_ahb_mem (.i_clk_sys, .i_rst_n, .i_ahb(o_ahb), .i_waits(waits), .o_hrdata(i_hrdata),
        .o_hready(i_hready));

    always #25 i_clk_sys = ~i_clk_sys;
    always @(negedge i_clk_sys)
    begin
        if (o_irq)
        begin
            irq_cnt++;
            `CHK("irq channel", 1'b1, trig_m[o_irq_ch])
        end
        if (o_busy && !busy_q)
            order.push_back(o_active_ch);
        busy_q = o_busy;
    end

    // ====================
    // helpers
    function automatic logic [7:0] pb(input int x);
        return 8'(x * 3 + 129);
    endfunction
    function automatic logic [31:0] sw(input int i);
        return {pb(4 * i + 3), pb(4 * i + 2), pb(4 * i + 1), pb(4 * i)};
    endfunction
    function automatic logic [31:0] gw(input int x);
        return u_dmade_ahb_mem.mem[x / 4];
    endfunction
    function automatic dmade_desc_s mk(input logic [1:0] md, input logic [3:0] fl, input logic [1:0] w,
                                       input logic [1:0] acc, input int n, input int s, input int d);
        mk = '0;
        {mk.valid, mk.irq_en, mk.invalidate_on_done, mk.auto_swap} = fl;
        {mk.mode, mk.source_step_enable, mk.dest_step_enable} = {md, 2'h3};
        {mk.source_access_width, mk.dest_access_width, mk.elem_width} = {acc, w};
        {mk.element_count, mk.src_addr, mk.dst_addr} = {16'(n), 32'(s), 32'(d)};
    endfunction
    task automatic fill();
        for (int i = 0; i < 64; i++)
            u_dmade_ahb_mem.mem[i] = (i < 32) ? sw(i) : 32'h0;
    endtask
    task automatic cfg(input int ch, input logic idx, input dmade_desc_s d);
        @(negedge i_clk_sys);
        {i_cfg_wr, i_cfg_ch, i_cfg_idx, i_cfg_desc} = {1'b1, 2'(ch), idx, d};
        @(negedge i_clk_sys);
        i_cfg_wr = 1'b0;
    endtask
    task automatic sel(input int ch, input logic v);
        @(negedge i_clk_sys);
        {i_sel_wr, i_sel_ch, i_sel_val} = {1'b1, 2'(ch), v};
        @(negedge i_clk_sys);
        i_sel_wr = 1'b0;
    endtask
    task automatic run(input logic [NCH-1:0] m);
        int t;
        @(negedge i_clk_sys);
        i_trig = m;
        trig_m = m;
        @(negedge i_clk_sys);
        i_trig = '0;
        `CHK("pending", m, o_pending & m)
        for (t = 0; t < 3000 && (o_busy || o_pending != '0); t++)
            @(negedge i_clk_sys);
        if (t >= 3000)
            failures++;
        repeat (2) @(negedge i_clk_sys);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ====================
    // tests
    initial
    begin
        {i_rst_n, i_trig, i_sel_wr, i_sel_ch, i_sel_val, i_cfg_wr, i_cfg_ch, i_cfg_idx} = '0;
        i_cfg_desc = '0;
        i_ch_en = 4'hF;
        i_ch_channel_priority_level = {2'h3, 2'h1, 2'h1, 2'h2};
        repeat (2) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        sel(0, 1'b0);
        // rows 0..7: 8 and 16 bit, all width pairs; row 8: word
        for (int r = 0; r < 9; r++)
        begin
            ew = (r == 8) ? 2'h2 : 2'(r / 4);
            aw = (r == 8) ? 2'h3 : 2'(r % 4);
            nb = 1 << ew;
            waits = 2'(r % 3);
            fill();
            cfg(0, 1'b0, mk(DMADE_MODE_DESC, 4'h8, ew, aw, 2, 32'h10, 32'h80));
            run(4'h1);
            for (int k = 0; k < 2; k++)
            begin
                {e, g} = '0;
                for (int b = 0; b < 4; b++)
                begin
                    a = 32'h80 + k * (aw[0] ? 4 : nb) + b;
                    if (b < nb)
                        e[b*8 +: 8] = pb(32'h10 + k * (aw[1] ? 4 : nb) + b);
                    if (b < nb || aw[0])
                        g[b*8 +: 8] = u_dmade_ahb_mem.mem[a / 4][(a % 4) * 8 +: 8];
                end
                `CHK("element", e, g)
            end
        end
        fill();
        sel(1, 1'b0);
        cfg(1, 1'b0, mk(DMADE_MODE_ONE, 4'hF, DMADE_EW_32, 2'h3, 3, 0, 32'h80));
        irq_cnt = 0;
        run(4'h2);
        `CHK("one element", {sw(0), 32'h0}, {gw(32'h80), gw(32'h84)})
        cfg(1, 1'b1, mk(DMADE_MODE_ONE, 4'h8, DMADE_EW_32, 2'h3, 1, 32'h20, 32'hC0));
        run(4'h2);
        run(4'h2);
        `CHK("third element", sw(2), gw(32'h88))
        `CHK("done irq", 1, irq_cnt)
        `CHK("select flip", 1'b1, o_desc_select[1])
        `CHK("no auto run", 32'h0, gw(32'hC0))
        run(4'h2);
        `CHK("second desc", sw(8), gw(32'hC0))
        `CHK("irq disabled", 1, irq_cnt)
        sel(1, 1'b0);
        u_dmade_ahb_mem.mem[32] = 32'h0;
        run(4'h2);
        `CHK("invalidated", 32'h0, gw(32'h80))
        fill();
        sel(2, 1'b0);
        cfg(2, 1'b0, mk(DMADE_MODE_CHAIN, 4'hD, DMADE_EW_32, 2'h3, 2, 0, 32'h80));
        cfg(2, 1'b1, mk(DMADE_MODE_CHAIN, 4'hF, DMADE_EW_32, 2'h3, 1, 32'h30, 32'hC0));
        irq_cnt = 0;
        run(4'h4);
        `CHK("chain", {sw(1), sw(12)}, {gw(32'h84), gw(32'hC0)})
        `CHK("chain irqs", 3, irq_cnt)
        `CHK("chain end", 1'b1, o_desc_select[2])
        cfg(3, 1'b0, mk(DMADE_MODE_CHAIN, 4'hC, DMADE_EW_32, 2'h3, 1, 0, 32'hE0));
        cfg(3, 1'b1, mk(DMADE_MODE_ONE, 4'h8, DMADE_EW_32, 2'h3, 1, 4, 32'hF0));
        sel(3, 1'b0);
        run(4'h8);
        `CHK("no chain", {sw(0), 32'h0, 1'b0}, {gw(32'hE0), gw(32'hF0), o_desc_select[3]})
        for (int c = 0; c < 4; c++)
        begin
            sel(c, 1'b0);
            cfg(c, 1'b0, mk(DMADE_MODE_ONE, 4'h8, DMADE_EW_32, 2'h3, 1, 4 * c, 32'h80 + 4 * c));
        end
        order.delete();
        run(4'hF);
        `CHK("order", {2'h1, 2'h2, 2'h0, 2'h3}, {order[0], order[1], order[2], order[3]})
        close_out();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        failures++;
        close_out();
    end
endmodule

bind dmade_engine dmade_engine_sva #(.NCH(NCH)) u_dmade_engine_sva (.i_clk_sys, .i_rst_n, .i_trig, .i_ch_en,
    .i_hready, .o_ahb, .o_pending, .o_busy, .o_irq);
